// [src/fsap_pkg.sv]
// Package with offsets, reset values, field positions and bus carrier for the flash setup block.
// What this block does
// - Erase, write and verify start address comes from the two pointer registers.
// - Pointers count upward toward the compare registers while no command executes.
// - Pointer registers accept both single-bit and whole-byte writes.
// - Reset leaves both pointer registers undefined.
// - Verify runs over the address range bounded by the compare registers.
// - Compare registers reset to 00H, are read/write, at FFA6H and FFA7H.
// - Byte-wide write buffer, whole-byte writes only, reset to 00H.
// - Protect byte at 0081H; bits 6 to 2 form the protect-select field.
// - Protection applies only in self-programming mode; a protected block is flagged on block_protected.
// - Four-block part: 01110 protects 3-0, 01111 protects 1-0, 11111 none.
// - Eight-block part: 01100 to 01111 protect 7,5,3,1 down to 0.
// - Sixteen-block part: 01000 to 01111 protect 15 down to 1, each to 0.
// - A write or erase command on a protected block, chosen by high pointer, raises protect error.
package fsap_pkg;
  localparam logic [15:0] FSAP_ADDR_PTR_LOW = 16'hffa4;
  localparam logic [15:0] FSAP_ADDR_PTR_HIGH = 16'hffa5;
  localparam logic [15:0] FSAP_ADDR_END_HIGH = 16'hffa6;
  localparam logic [15:0] FSAP_ADDR_END_LOW = 16'hffa7;
  localparam logic [15:0] FSAP_WRITE_BUF = 16'hffa8;
  localparam logic [15:0] FSAP_PROTECT_BYTE_LOC = 16'h0081;
  localparam logic [7:0] FSAP_END_RESET = 8'h00;
  localparam logic [7:0] FSAP_WBUF_RESET = 8'h00;
  localparam logic [7:0] FSAP_RDATA_RESET = 8'h00;
  localparam int FSAP_SEL_LSB = 2;
  localparam int FSAP_SEL_MSB = 6;
  localparam logic [4:0] FSAP_SEL_NONE = 5'h1f;
  localparam logic [1:0] FSAP_SEL_TOP_HI = 2'h1;

  typedef struct packed {
    logic [15:0] addr;
    logic wr_byte;
    logic wr_bit;
    logic [2:0] bit_sel;
    logic bit_val;
    logic [7:0] wdata;
    logic rd;
  } fsap_cpu_req_s;
endpackage

// [src/fsap_top.sv]
// Address pointers, compare registers, write buffer and protect decode for flash self-programming.
module fsap_top import fsap_pkg::*; #(
  parameter int NUM_BLOCKS = 16
) (
  input wire logic sys_clk, // System clock, 100 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire fsap_cpu_req_s cpu_req, // CPU memory access request.
  output logic [7:0] cpu_rdata, // Read data, valid the cycle after a read.
  input wire logic self_prog_mode, // High while in self-programming mode.
  input wire logic cmd_exec, // High while a programming command executes.
  input wire logic cmd_start, // One-cycle pulse when a command starts.
  input wire logic cmd_modify, // High when the starting command writes or erases.
  input wire logic [7:0] protect_byte, // Non-volatile protect byte contents.
  output logic [11:0] flash_addr, // Start address toward the flash array.
  output logic [11:0] flash_end_addr, // End address of the verify range.
  output logic [7:0] flash_wdata, // Data to be programmed.
  output logic block_protected, // Addressed block is protected now.
  output logic protect_err_set // One-cycle pulse to set the protect error flag.
);
  logic [7:0] ptr_low_q, ptr_low_d;
  logic [7:0] ptr_high_q, ptr_high_d;
  logic [7:0] end_high_q, end_high_d;
  logic [7:0] end_low_q, end_low_d;
  logic [7:0] wbuf_q, wbuf_d;
  logic [7:0] rdata_q, rdata_d;
  logic prot_q, prot_d;
  logic perr_q, perr_d;
  logic [11:0] ptr_cat;
  logic [11:0] end_cat;
  logic [11:0] ptr_inc;
  logic [4:0] sel;
  logic [3:0] top_block;
  logic sel_valid;
  logic any_wr;
  logic at_end;
  logic count_en;

  // A byte write takes the whole byte; a bit write changes only the selected bit.
  function automatic logic [7:0] fsap_wr(input logic [7:0] cur, input fsap_cpu_req_s r);
    logic [7:0] v;
    v = cur;
    if (r.wr_byte) begin
      v = r.wdata;
    end else if (r.wr_bit) begin
      v[r.bit_sel] = r.bit_val;
    end
    return v;
  endfunction

  assign ptr_cat = {ptr_high_q[3:0], ptr_low_q};
  assign end_cat = {end_high_q[3:0], end_low_q};
  assign ptr_inc = ptr_cat + 12'h001;
  assign any_wr = cpu_req.wr_byte | cpu_req.wr_bit;
  assign sel = protect_byte[FSAP_SEL_MSB:FSAP_SEL_LSB];

  // Counting runs only while idle and stops once the pointer reaches the end address.
  assign at_end = (ptr_cat == end_cat);
  assign count_en = !cmd_exec && !at_end;

  // Each step of the select field up from 01000 frees the two highest protected blocks.
  // The smaller variants accept only the upper part of that range.
  // Highest protected block is 1 + 2*(15 - sel[3:0]) for select values 01xxx.
  always_comb begin
    top_block = {~sel[2:0], 1'b1};
    sel_valid = 1'b0;
    if (sel[4:3] == FSAP_SEL_TOP_HI) begin
      if (NUM_BLOCKS == 4) begin
        sel_valid = (sel[2:1] == 2'h3);
      end else if (NUM_BLOCKS == 8) begin
        sel_valid = sel[2];
      end else begin
        sel_valid = 1'b1;
      end
    end
  end

  // A software write in any cycle holds the pointers, so a reload is never lost to counting.
  always_comb begin
    ptr_low_d = ptr_low_q;
    ptr_high_d = ptr_high_q;
    if (any_wr) begin
      unique case (cpu_req.addr)
        FSAP_ADDR_PTR_LOW: ptr_low_d = fsap_wr(ptr_low_q, cpu_req);
        FSAP_ADDR_PTR_HIGH: ptr_high_d = fsap_wr(ptr_high_q, cpu_req);
        default: begin
        end
      endcase
    end else if (count_en) begin
      ptr_low_d = ptr_inc[7:0];
      ptr_high_d = {ptr_high_q[7:4], ptr_inc[11:8]};
    end
  end

  always_comb begin
    end_high_d = end_high_q;
    end_low_d = end_low_q;
    if (any_wr && (cpu_req.addr == FSAP_ADDR_END_HIGH)) begin
      end_high_d = fsap_wr(end_high_q, cpu_req);
    end
    if (any_wr && (cpu_req.addr == FSAP_ADDR_END_LOW)) begin
      end_low_d = fsap_wr(end_low_q, cpu_req);
    end
  end

  // Bit writes to the buffer are refused; only a whole byte lands.
  always_comb begin
    wbuf_d = wbuf_q;
    if (cpu_req.wr_byte && (cpu_req.addr == FSAP_WRITE_BUF)) begin
      wbuf_d = cpu_req.wdata;
    end
  end

  // Read data stands for one cycle; unmapped addresses read as zero.
  always_comb begin
    rdata_d = FSAP_RDATA_RESET;
    if (cpu_req.rd) begin
      unique case (cpu_req.addr)
        FSAP_ADDR_PTR_LOW: rdata_d = ptr_low_q;
        FSAP_ADDR_PTR_HIGH: rdata_d = ptr_high_q;
        FSAP_ADDR_END_HIGH: rdata_d = end_high_q;
        FSAP_ADDR_END_LOW: rdata_d = end_low_q;
        FSAP_WRITE_BUF: rdata_d = wbuf_q;
        default: rdata_d = FSAP_RDATA_RESET;
      endcase
    end
  end

  // One compare per block: a block is covered when it lies at or below the top block.
  logic [15:0] blk_in_range;
  for (genvar b = 0; b < 16; b++) begin : g_blk
    assign blk_in_range[b] = (4'(b) <= top_block);
  end

  // Prohibited select values protect every block, the safe reading of an illegal setting.
  always_comb begin
    prot_d = 1'b0;
    if (self_prog_mode && (sel != FSAP_SEL_NONE)) begin
      prot_d = !sel_valid || blk_in_range[ptr_high_q[3:0]];
    end
    perr_d = cmd_start && cmd_modify && prot_d;
  end

  // Pointers carry no reset; their contents after reset are undefined.
  always_ff @(posedge sys_clk) begin
    ptr_low_q <= ptr_low_d;
    ptr_high_q <= ptr_high_d;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      end_high_q <= FSAP_END_RESET;
      end_low_q <= FSAP_END_RESET;
    end else begin
      end_high_q <= end_high_d;
      end_low_q <= end_low_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wbuf_q <= FSAP_WBUF_RESET;
    end else begin
      wbuf_q <= wbuf_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= FSAP_RDATA_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // The protect level and the error pulse leave the block straight from these flops.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_q <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      prot_q <= prot_d;
      perr_q <= perr_d;
    end
  end

  // Output stage: the array sees start, end and data one cycle after the registers.
  logic [11:0] faddr_q, faddr_d;
  logic [11:0] fend_q, fend_d;
  logic [7:0] fdata_q, fdata_d;

  always_comb begin
    faddr_d = ptr_cat;
    fend_d = end_cat;
    fdata_d = wbuf_q;
  end

  // The start address follows the pointers, so it has no reset either.
  always_ff @(posedge sys_clk) begin
    faddr_q <= faddr_d;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fend_q <= {FSAP_END_RESET[3:0], FSAP_END_RESET};
      fdata_q <= FSAP_WBUF_RESET;
    end else begin
      fend_q <= fend_d;
      fdata_q <= fdata_d;
    end
  end


  assign cpu_rdata = rdata_q;
  assign flash_addr = faddr_q;
  assign flash_end_addr = fend_q;
  assign flash_wdata = fdata_q;
  assign block_protected = prot_q;
  assign protect_err_set = perr_q;
endmodule

// [dv/fsap_props.sv]
// Port-level checks for the flash setup block.
module fsap_props import fsap_pkg::*; (
  input wire logic sys_clk, input wire logic rst_n, input wire fsap_cpu_req_s cpu_req,
  input wire logic [7:0] cpu_rdata, input wire logic self_prog_mode, input wire logic cmd_exec,
  input wire logic cmd_start, input wire logic cmd_modify, input wire logic [7:0] protect_byte,
  input wire logic [11:0] flash_addr, input wire logic [11:0] flash_end_addr,
  input wire logic [7:0] flash_wdata, input wire logic block_protected,
  input wire logic protect_err_set
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire wr = cpu_req.wr_byte | cpu_req.wr_bit;
  wire [15:0] a = cpu_req.addr;
  end_read_a: assert property (cpu_req.rd && !wr && a == FSAP_ADDR_END_LOW |=>
    cpu_rdata == flash_end_addr[7:0]) else $error("end read wrong");
  wbuf_load_a: assert property (cpu_req.wr_byte && a == FSAP_WRITE_BUF |=> ##1
    flash_wdata == $past(cpu_req.wdata, 2)) else $error("buffer not loaded");
  wbuf_bit_a: assert property (!cpu_req.wr_byte && cpu_req.wr_bit && a == FSAP_WRITE_BUF
    |=> ##1 $stable(flash_wdata)) else $error("buffer took bit write");
  ptr_load_a: assert property (cpu_req.wr_byte && a == FSAP_ADDR_PTR_LOW |=> ##1
    flash_addr[7:0] == $past(cpu_req.wdata, 2)) else $error("pointer not loaded");
  ptr_hold_a: assert property (cmd_exec && !wr && flash_addr != flash_end_addr |=>
    ##1 $stable(flash_addr)) else $error("pointer moved");
  ptr_count_a: assert property ($past(rst_n && !cmd_exec && !wr)
    && flash_addr != flash_end_addr |=> flash_addr == $past(flash_addr) + 12'h1)
    else $error("pointer did not count");
  err_cause_a: assert property (protect_err_set |->
    $past(cmd_start && cmd_modify && self_prog_mode)) else $error("stray protect error");
  mode_gate_a: assert property (!self_prog_mode |=> !block_protected)
    else $error("protected outside mode");
  prot_none_a: assert property (protect_byte[FSAP_SEL_MSB:FSAP_SEL_LSB] == FSAP_SEL_NONE |=>
    !block_protected) else $error("protected with none selected");
  cover property (protect_err_set);
  cover property (block_protected);
  cover property (cmd_exec && flash_addr != flash_end_addr);
endmodule
bind fsap_top fsap_props i_props (.*);

// [dv/fsap_flash_model.sv]
// Behavioural flash side: command timing and the protect byte contents.
module fsap_flash_model (
  input wire logic sys_clk, input wire logic rst_n, input wire logic go,
  input wire logic modify, input wire logic [4:0] sel, output logic cmd_start,
  output logic cmd_exec, output logic cmd_modify, output logic [7:0] protect_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  assign cmd_start = go & ~cmd_exec;
  assign cmd_modify = modify;
  assign protect_byte = {1'b1, sel, 2'b11};
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) cmd_exec <= 1'b0;
    else cmd_exec <= go;
  end
endmodule

// [dv/fsap_top_test.sv]
// Self-checking bench for the flash setup block.
module fsap_top_test import fsap_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, rst_n = 1'b0, self_prog_mode = 1'b0, go = 1'b0, modify = 1'b0;
  fsap_cpu_req_s cpu_req = '0;
  logic [4:0] sel = 5'h1f;
  logic [7:0] cpu_rdata, protect_byte, flash_wdata;
  logic [11:0] flash_addr, flash_end_addr;
  logic cmd_exec, cmd_start, cmd_modify, block_protected, protect_err_set;
  int errors = 0, checked = 0;
  fsap_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .self_prog_mode(self_prog_mode), .cmd_exec(cmd_exec), .cmd_start(cmd_start),
    .cmd_modify(cmd_modify), .protect_byte(protect_byte), .flash_addr(flash_addr),
    .flash_end_addr(flash_end_addr), .flash_wdata(flash_wdata),
    .block_protected(block_protected), .protect_err_set(protect_err_set));
  fsap_flash_model i_flash (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .modify(modify),
    .sel(sel), .cmd_start(cmd_start), .cmd_exec(cmd_exec), .cmd_modify(cmd_modify),
    .protect_byte(protect_byte));
  initial forever #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("Error %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic summarize();
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic acc(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cpu_req <= '{a, k == 2'h0, k == 2'h1, d[2:0], d[3], d, k == 2'h2};
    @(posedge sys_clk);
    cpu_req <= '0;
    @(negedge sys_clk);
  endtask
  task automatic setp(input logic [3:0] b, input logic [7:0] lo, input logic [7:0] e);
    @(posedge sys_clk) go <= 1'b1;
    acc(2'h0, FSAP_ADDR_PTR_HIGH, {4'h0, b});
    acc(2'h0, FSAP_ADDR_PTR_LOW, lo);
    acc(2'h0, FSAP_ADDR_END_HIGH, {4'h0, b});
    acc(2'h0, FSAP_ADDR_END_LOW, e);
    @(posedge sys_clk) go <= 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic t_reset();
    for (int k = 0; k < 4; k++) begin
      acc(2'h2, FSAP_ADDR_END_HIGH + 16'(k), 8'h00);
      chk(cpu_rdata, 8'h00);
    end
    chk(flash_end_addr, 12'h000);
    chk(flash_wdata, 8'h00);
  endtask
  task automatic t_wbuf();
    acc(2'h0, FSAP_WRITE_BUF, 8'ha5);
    acc(2'h1, FSAP_WRITE_BUF, 8'h00);
    acc(2'h2, FSAP_WRITE_BUF, 8'h00);
    chk(cpu_rdata, 8'ha5);
    chk(flash_wdata, 8'ha5);
  endtask
  task automatic t_count();
    setp(4'h3, 8'h7c, 8'h7f);
    chk(flash_addr, 12'h37c);
    repeat (6) @(negedge sys_clk);
    chk(flash_addr, 12'h37f);
    chk(flash_end_addr, 12'h37f);
    acc(2'h1, FSAP_ADDR_PTR_HIGH, 8'h00);
    acc(2'h2, FSAP_ADDR_PTR_HIGH, 8'h00);
    chk(cpu_rdata, 8'h02);
    repeat (300) @(negedge sys_clk);
    chk(flash_addr, 12'h37f);
  endtask
  task automatic t_prot();
    @(posedge sys_clk) self_prog_mode <= 1'b1;
    for (int i = 8; i < 16; i++) begin
      @(posedge sys_clk) sel <= 5'(i);
      setp(4'(31 - 2 * i), 8'h00, 8'h00);
      chk(block_protected, 1'b1);
      if (i > 8) begin
        setp(4'(32 - 2 * i), 8'h00, 8'h00);
        chk(block_protected, 1'b0);
      end
    end
    setp(4'h0, 8'h00, 8'h00);
    @(posedge sys_clk) {go, modify} <= 2'h3;
    @(posedge sys_clk) {go, modify} <= 2'h0;
    @(negedge sys_clk) chk(protect_err_set, 1'b1);
    @(negedge sys_clk) chk(protect_err_set, 1'b0);
    @(posedge sys_clk) sel <= FSAP_SEL_NONE;
    repeat (2) @(negedge sys_clk);
    chk(block_protected, 1'b0);
    @(posedge sys_clk) {go, modify} <= 2'h3;
    @(posedge sys_clk) {go, modify} <= 2'h0;
    @(negedge sys_clk) chk(protect_err_set, 1'b0);
    @(posedge sys_clk) sel <= 5'h00;
    repeat (2) @(negedge sys_clk);
    chk(block_protected, 1'b1);
    @(posedge sys_clk) {sel, self_prog_mode} <= {5'h0f, 1'b0};
    repeat (2) @(negedge sys_clk);
    chk(block_protected, 1'b0);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_wbuf();
    t_count();
    t_prot();
    summarize();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    summarize();
  end
endmodule
